/* File: design/tsx_addr.sv */
// file operand address former
// assumes bank and pointer values are stable within the cycle
`timescale 1ns/10ps
module tsx_addr
  import tsx_pkg::*;
(
  input  wire logic [7:0]  f,
  input  wire logic        a,
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] third_file_select_pointer,
  output logic      [11:0] addr,
  output logic             ilo
);

  // ----------------------------------------------------------------
  // address selection
  // ----------------------------------------------------------------
  // access bank is split: low part at 0x000, sfr part in bank 0xf
  wire        lo_part = f < ACC_SPLIT;
  wire [11:0] acc_a   = lo_part ? {4'h0, f} : {ACC_HIGH, f};
  wire [11:0] bank_a  = {bank, f};
  wire [11:0] ilo_a   = 12'(third_file_select_pointer + {4'h0, f});

  assign ilo  = ~a & ext_en & (f <= ILO_MAX);          // see RULE4
  assign addr = ilo ? ilo_a : (a ? bank_a : acc_a);    // see RULE3

endmodule : tsx_addr

/* File: design/tsx_alu.sv */
// xor datapath and flag generation
// assumes purely combinational use inside one instruction cycle
`timescale 1ns/10ps
module tsx_alu
  import tsx_pkg::*;
(
  input  wire logic [7:0] work,
  input  wire logic [7:0] opnd,
  output logic      [7:0] res,
  output logic            res_zero,
  output logic            res_neg,
  output logic            opnd_zero
);

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  assign res       = work ^ opnd;          // see RULE5 see RULE6
  assign res_zero  = res == 8'h00;         // see RULE12
  assign res_neg   = res[7];               // see RULE12
  assign opnd_zero = opnd == 8'h00;        // see RULE1

endmodule : tsx_alu

/* File: design/tsx_core.sv */
// execution core for test-skip, xor and pointer-literal instructions
// assumes an avalon-mm master with waitrequest and a static fuse pin
`timescale 1ns/10ps

// Behaviour
// RULE1: test-skip of a zero register drops the fetched word: two cycles.
// RULE2: skipped two-word instruction costs one more nop, three cycles total.
// RULE3: access bit 0 selects access bank, 1 uses bank select register.
// RULE4: access 0, extension on, operand up to 95: indexed literal offset.
// RULE5: xor literal into work register, one word, one cycle.
// RULE6: xor work with file, destination bit picks work or file.
// RULE7: xors touch only negative and zero flags; test-skip touches none.
// RULE8: base set plus optional eight indexed-addressing instructions.
// RULE9: extension on when unprogrammed; fuse alone enables or disables it.
// RULE10: extended instructions are literal ops on file select pointers.
// RULE11: pointer-and-return forms act on third pointer, then return.
// RULE12: xor zero flag on zero result, negative flag from bit 7.
module tsx_core
  import tsx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        extension_enable_fuse,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------------------------------
  // reset release and instruction-cycle divider
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] div_reg;
  logic       ce;

  // asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_reg <= 2'b00;
    else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // one enable pulse per four clocks, the q1..q4 of a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_reg <= 2'b00;
    else        div_reg <= (div_reg == DIV_LAST) ? 2'b00 : div_reg + 2'b01;
  end
  assign ce = div_reg == DIV_LAST;

  // ----------------------------------------------------------------
  // fuse capture
  // ----------------------------------------------------------------
  logic [2:0] fz_reg;
  logic [2:0] fv_reg;
  logic       fuse_reg;
  logic       fuse_done_reg;

  // the fuse is read once after release; later pin changes are ignored
  // because the setting belongs to programming time only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fz_reg        <= 3'b000;
      fv_reg        <= 3'b000;
      fuse_reg      <= FUSE_RST;          // see RULE9
      fuse_done_reg <= 1'b0;
    end else begin
      fz_reg <= {fz_reg[1:0], extension_enable_fuse};
      fv_reg <= {fv_reg[1:0], 1'b1};
      // compare only once both stages hold real pin samples
      if (!fuse_done_reg && fv_reg[2] && fz_reg[1] == fz_reg[2]) begin
        fuse_reg      <= fz_reg[2];       // see RULE9
        fuse_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  logic [15:0]        pmem [2**PMEM_AW];
  logic [7:0]         dmem [4096];
  logic [15:0]        ir_reg;
  logic [PMEM_AW-1:0] pc_reg, tos_reg;
  logic [7:0]         work_reg;
  logic [3:0]         bank_reg;
  logic [11:0]        fsr_reg [3];
  logic               neg_reg, zero_reg, run_reg;
  logic [11:0]        daddr_reg;
  tsx_state_t         state_reg, state_next;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire ext_en  = fuse_done_reg & fuse_reg;                // see RULE9
  wire is_tst  = ir_reg[15:9]  == OPC_TST;
  wire is_xlw  = ir_reg[15:8]  == OPC_XOR_LITERAL_INTO_WORK;
  wire is_xwf  = ir_reg[15:10] == OPC_XOR_WORK_WITH_FILE;
  // extended words decode only with the extension on      see RULE8
  wire is_fsrk = ext_en & (ir_reg[15:9] == OPC_FSRK);    // see RULE10
  wire [1:0] fsr_sel = ir_reg[7:6];
  wire is_ulnk = is_fsrk & (fsr_sel == FSR_ULNK);        // see RULE11
  wire [1:0] fsr_idx = is_ulnk ? 2'd2 : fsr_sel;
  wire [11:0] fsr_k  = {6'h00, ir_reg[5:0]};
  wire [11:0] fsr_old = fsr_reg[fsr_idx];
  wire [11:0] fsr_new = ir_reg[8] ? 12'(fsr_old - fsr_k)
                                  : 12'(fsr_old + fsr_k);
  // wrong-path or second words that fall into a skip
  wire two_word = (ir_reg[15:12] == OPC_2W_A) |
                  (ir_reg[15:8] >= OPC_2W_LO && ir_reg[15:8] <= OPC_2W_HI);

  wire exec = ce & run_reg & (state_reg == ST_EXEC);

  // ----------------------------------------------------------------
  // operand path
  // ----------------------------------------------------------------
  logic [11:0] faddr;
  logic [7:0]  res;
  logic        res_zero, res_neg, opnd_zero;

  tsx_addr u_addr (
    .f      (ir_reg[7:0]),
    .a      (ir_reg[8]),
    .ext_en (ext_en),
    .bank   (bank_reg),
    .third_file_select_pointer   (fsr_reg[2]),
    .addr   (faddr),
    .ilo    ()
  );

  wire [7:0] file_val = dmem[faddr];
  wire [7:0] opnd     = is_xlw ? ir_reg[7:0] : file_val;

  tsx_alu u_alu (
    .work      (work_reg),
    .opnd      (opnd),
    .res       (res),
    .res_zero  (res_zero),
    .res_neg   (res_neg),
    .opnd_zero (opnd_zero)
  );

  wire tst_skip = exec & is_tst & opnd_zero;             // see RULE1
  wire wr_work  = exec & (is_xlw | (is_xwf & ~ir_reg[9])); // see RULE6
  wire wr_file  = exec & is_xwf & ir_reg[9];             // see RULE6
  wire wr_flags = exec & (is_xlw | is_xwf);              // see RULE7
  wire wr_fsr   = exec & is_fsrk;

  // ----------------------------------------------------------------
  // skip sequencer
  // ----------------------------------------------------------------
  // drop: the discarded word runs as nop; a two-word one adds a nop
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_EXEC: begin
        if (tst_skip)     state_next = ST_DROP;          // see RULE1
        else if (exec && is_ulnk) state_next = ST_LAST;  // see RULE11
      end
      ST_DROP: begin
        if (ce) state_next = two_word ? ST_LAST : ST_EXEC; // see RULE2
      end
      ST_LAST: begin
        if (ce) state_next = ST_EXEC;
      end
      default: state_next = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_reg <= ST_EXEC;
    else        state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] rdata_reg;
  wire         req     = avs_read | avs_write;
  // writes land at the edge where waitrequest is seen low
  wire         bus_wr  = avs_write & ack_reg;
  // state writes are honoured only while the core is halted
  wire         st_wr   = bus_wr & ~run_reg;
  wire         pwin    = avs_address[11:10] == A_PWIN;
  wire [PMEM_AW-1:0] pidx = avs_address[PMEM_AW+1:2];
  wire [7:0]   wd8     = avs_writedata[7:0];
  wire [11:0]  wd12    = avs_writedata[11:0];
  wire         w_bank  = st_wr & (avs_address == A_BANK);
  wire         w_work  = st_wr & (avs_address == A_WORK);
  wire         w_pc    = st_wr & (avs_address == A_PC);
  wire         w_tos   = st_wr & (avs_address == A_TOS);
  wire         w_daddr = st_wr & (avs_address == A_DADDR);
  wire         w_ddata = st_wr & (avs_address == A_DDATA);
  wire         w_fsr0  = st_wr & (avs_address == A_FSR0);
  wire         w_fsr1  = st_wr & (avs_address == A_FSR1);
  wire         w_third_file_select_pointer  = st_wr & (avs_address == A_THIRD_FILE_SELECT_POINTER);

  // every access waits one cycle, answered at the second edge
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  wire [31:0] stat_val = {24'h0, state_reg, fuse_done_reg, ext_en,
                          run_reg, neg_reg, zero_reg};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (pwin) rd_mux = {16'h0, pmem[pidx]};
    else begin
      unique case (avs_address)
        A_CTRL:  rd_mux = {31'h0, run_reg};
        A_STAT:  rd_mux = stat_val;
        A_WORK:  rd_mux = {24'h0, work_reg};
        A_BANK:  rd_mux = {28'h0, bank_reg};
        A_FSR0:  rd_mux = {20'h0, fsr_reg[0]};
        A_FSR1:  rd_mux = {20'h0, fsr_reg[1]};
        A_THIRD_FILE_SELECT_POINTER:  rd_mux = {20'h0, fsr_reg[2]};
        A_PC:    rd_mux = {26'h0, pc_reg};
        A_TOS:   rd_mux = {26'h0, tos_reg};
        A_DADDR: rd_mux = {20'h0, daddr_reg};
        A_DDATA: rd_mux = {24'h0, dmem[daddr_reg]};
        default: rd_mux = 32'h0;          // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read && !ack_reg) rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // memories (no reset, contents loaded over the bus)
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_file)      dmem[faddr]     <= res;          // see RULE6
    else if (w_ddata) dmem[daddr_reg] <= wd8;
    if (st_wr && pwin) pmem[pidx] <= avs_writedata[15:0];
  end

  // ----------------------------------------------------------------
  // fetch and program counter
  // ----------------------------------------------------------------
  // fetch always runs one word ahead; skips discard it, not refetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= '0;
      ir_reg <= 16'h0000;
    end else if (ce && run_reg) begin
      ir_reg <= pmem[pc_reg];
      if (exec && is_ulnk) pc_reg <= tos_reg;          // see RULE11
      else                 pc_reg <= pc_reg + PMEM_AW'(1);
    end else if (w_pc) begin
      pc_reg <= avs_writedata[PMEM_AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // working register, flags, bank and control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg <= 8'h00;
      neg_reg  <= 1'b0;
      zero_reg <= 1'b0;
    end else begin
      if (wr_work)     work_reg <= res;                // see RULE5
      else if (w_work) work_reg <= wd8;
      if (wr_flags) begin                              // see RULE7
        neg_reg  <= res_neg;                           // see RULE12
        zero_reg <= res_zero;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg  <= 4'h0;
      tos_reg   <= '0;
      daddr_reg <= 12'h000;
      run_reg   <= 1'b0;
    end else begin
      if (w_bank)  bank_reg  <= avs_writedata[3:0];
      if (w_tos)   tos_reg   <= avs_writedata[PMEM_AW-1:0];
      if (w_daddr) daddr_reg <= wd12;
      if (bus_wr && avs_address == A_CTRL)
        run_reg <= avs_writedata[CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // file select pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsr_reg[0] <= 12'h000;
      fsr_reg[1] <= 12'h000;
      fsr_reg[2] <= 12'h000;
    end else if (wr_fsr) begin
      fsr_reg[fsr_idx] <= fsr_new;                     // see RULE10
    end else begin
      if (w_fsr0) fsr_reg[0] <= wd12;
      if (w_fsr1) fsr_reg[1] <= wd12;
      if (w_third_file_select_pointer) fsr_reg[2] <= wd12;
    end
  end

endmodule : tsx_core

/* File: design/tsx_pkg.sv */
// shared constants and types of the test/skip/xor execution core
// assumes a single 100 MHz clock and an avalon-mm register slave
package tsx_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;   // clk period
  localparam int ICYC_NS        = 40;   // one instruction cycle (4 q)
  localparam int CYCLE_CLKS     = ICYC_NS / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_LAST = 2'(CYCLE_CLKS - 1);

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STAT   = 12'h004;
  localparam logic [11:0] A_WORK   = 12'h008;
  localparam logic [11:0] A_BANK   = 12'h00c;
  localparam logic [11:0] A_FSR0   = 12'h010;
  localparam logic [11:0] A_FSR1   = 12'h014;
  localparam logic [11:0] A_THIRD_FILE_SELECT_POINTER   = 12'h018;
  localparam logic [11:0] A_PC     = 12'h01c;
  localparam logic [11:0] A_TOS    = 12'h020;
  localparam logic [11:0] A_DADDR  = 12'h024;
  localparam logic [11:0] A_DDATA  = 12'h028;
  localparam logic [1:0]  A_PWIN   = 2'b01;   // 0x400..0x7ff, the 64 words repeat every 0x100
  localparam int          PMEM_AW  = 6;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int   CTRL_RUN_BIT = 0;
  localparam logic FUSE_RST     = 1'b1;   // unprogrammed: extension on
  localparam logic [7:0] ILO_MAX   = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HIGH  = 4'hf;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_TST   = 7'b0110011;  // [15:9]
  localparam logic [7:0] OPC_XOR_LITERAL_INTO_WORK = 8'h0a;       // [15:8]
  localparam logic [5:0] OPC_XOR_WORK_WITH_FILE = 6'b000110;   // [15:10]
  localparam logic [6:0] OPC_FSRK  = 7'b1110100;  // [15:9]
  localparam logic [3:0] OPC_2W_A  = 4'hc;        // [15:12]
  localparam logic [7:0] OPC_2W_LO = 8'heb;       // [15:8] range
  localparam logic [7:0] OPC_2W_HI = 8'hef;
  localparam logic [1:0] FSR_ULNK  = 2'b11;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_DROP = 3'b010,
    ST_LAST = 3'b100
  } tsx_state_t;

endpackage : tsx_pkg

/* File: verif/tb_test_skip_and_xor_execution.sv */
// self-checking bench: loads programs, runs them, checks results
// assumes one tsx_core driven over avalon-mm, fuse changed in reset
`timescale 1ns/10ps
module tb_test_skip_and_xor_execution;
  import tsx_pkg::*;
  logic        clk, arst_n, fuse, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [31:0] seed;
  int          fails, checks_done;
  tsx_core tsx_core_inst (
    .clk(clk), .arst_n(arst_n), .extension_enable_fuse(fuse),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] flags_of(input logic [7:0] r);
    return {30'h0, r[7], r == 8'h00};
  endfunction : flags_of
  function automatic logic [7:0] rnd8();
    seed = lfsr_next(seed);
    return seed[7:0];
  endfunction : rnd8
  // raise after an edge, hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) fails++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic check(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(A_DADDR, {20'h0, a});
    wr(A_DDATA, {24'h0, d});
  endtask : mem_wr
  task automatic mem_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    wr(A_DADDR, {20'h0, a});
    rd(A_DDATA, q);
    check("data byte", {24'h0, e}, q);
  endtask : mem_chk
  task automatic do_reset(input logic fz);
    logic [31:0] q;
    int n;
    arst_n <= 1'b0;
    fuse <= fz;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    n = 0;
    do begin
      rd(A_STAT, q);
      n++;
    end while (q[4] !== 1'b1 && n < 20);
    check("fuse done", 32'h1, {31'h0, q[4]});
  endtask : do_reset
  // ------------------------------------------------------------
  // one program: skips, xors, indexed operand, pointer literals
  // ------------------------------------------------------------
  task automatic run_prog(input logic ext, zk, sub);
    logic [7:0]  w0, k1, k2, k3, k4, v1, v3, w, ix;
    logic [11:0] f1;
    logic [15:0] p [12];
    logic [31:0] q;
    w0 = rnd8();
    k1 = rnd8() | 8'h01;
    k2 = rnd8() | 8'h01;
    k3 = rnd8();
    v1 = rnd8();
    v3 = rnd8();
    f1 = 12'({rnd8(), rnd8()});
    w = w0 ^ k3;
    ix = w ^ v1;
    w = w ^ v3;
    k4 = zk ? w : rnd8();
    w = w ^ k4;
    p = '{16'h6680, {8'h0a, k1}, 16'h6730, 16'hc123, {8'h0a, k2},
          {8'h0a, k3}, 16'h1a10, 16'h1940, {8'h0a, k4}, 16'h6660,
          16'he845, sub ? 16'he9c3 : 16'he8c3};
    foreach (p[i]) wr(12'h400 + 12'(4 * i), {16'h0, p[i]});
    mem_wr(12'hf80, 8'h00);
    mem_wr(12'h230, 8'h00);
    mem_wr(12'h110, v1);
    mem_wr(12'h010, v1);
    mem_wr(12'h240, v3);
    mem_wr(12'h040, ~v3);
    mem_wr(12'hf60, rnd8() | 8'h01);
    wr(A_WORK, {24'h0, w0});
    wr(A_BANK, 32'h2);
    wr(A_FSR1, {20'h0, f1});
    wr(A_THIRD_FILE_SELECT_POINTER, 32'h100);
    wr(A_TOS, 32'h20);
    wr(A_PC, 32'h0);
    wr(A_CTRL, 32'h1);
    wr(A_WORK, 32'hff);  // refused while running
    repeat (100) @(posedge clk);
    wr(A_CTRL, 32'h0);
    rd(A_WORK, q);
    check("work", {24'h0, w}, q);
    rd(A_STAT, q);
    check("flags", flags_of(w), {30'h0, q[1:0]});
    check("ext on", {31'h0, ext}, {31'h0, q[3]});
    mem_chk(12'h110, ext ? ix : v1);
    mem_chk(12'h010, ext ? v1 : ix);
    mem_chk(12'h240, v3);
    rd(A_FSR1, q);
    check("fsr1", {20'h0, ext ? f1 + 12'h5 : f1}, q);
    rd(A_THIRD_FILE_SELECT_POINTER, q);
    check("third_file_select_pointer", ext ? (sub ? 32'hfd : 32'h103) : 32'h100, q);
  endtask : run_prog
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    logic [31:0] q;
    arst_n = 1'b0;
    fuse = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h0;
    avs_writedata = 32'h0;
    seed = 32'hbce2;
    fails = 0;
    checks_done = 0;
    do_reset(1'b1);
    run_prog(1'b1, 1'b1, 1'b0);
    $display("test 1 done");
    run_prog(1'b1, 1'b0, 1'b1);
    rd(12'h900, q);
    check("unmapped", 32'h0, q);
    $display("test 2 done");
    do_reset(1'b0);
    run_prog(1'b0, 1'b0, 1'b0);
    $display("test 3 done");
    conclude();
  end
endmodule : tb_test_skip_and_xor_execution

/* File: verif/tsx_core_checker.sv */
// bus-port checker for the execution core
// assumes it is bound to the core and sees only its ports
`timescale 1ns/10ps
module tsx_core_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        extension_enable_fuse,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  import tsx_pkg::*;
  // ------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire rd_done = avs_read & ~avs_waitrequest;  // read sampled here
  wire st_rd   = rd_done & (avs_address == A_STAT);
  sequence s_req_start;
    $rose(avs_read | avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req_start |-> s_one_wait)
    else $error("request did not see exactly one wait state");
  a_ack_bounded: assert property
    ((avs_read | avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("request left waiting too long");
  // readdata only moves at the edge where a read is seen with waitrequest high
  a_rdata_hold: assert property
    (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("readdata moved without a read");
  a_unmapped_zero: assert property
    (rd_done && avs_address >= 12'h800 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ------------------------------------------------------------
  // status and work register contents
  // ------------------------------------------------------------
  a_stat_fuse: assert property
    (st_rd && avs_readdata[4] |-> avs_readdata[3] == extension_enable_fuse)
    else $error("extension state differs from fuse");
  a_stat_upper: assert property
    (st_rd |-> avs_readdata[31:8] == 24'h0)
    else $error("status upper bits not zero");
  a_state_onehot: assert property
    (st_rd |-> $onehot(avs_readdata[7:5]))
    else $error("sequencer state not one-hot");
  a_work_narrow: assert property
    (rd_done && avs_address == A_WORK |-> avs_readdata[31:8] == 24'h0)
    else $error("work register wider than a byte");
endmodule : tsx_core_checker

bind tsx_core tsx_core_checker tsx_core_checker_inst (.*);
